//--- logic/i2c_status_defs.svh
`ifndef I2C_STATUS_DEFS_SVH
`define I2C_STATUS_DEFS_SVH
// register offsets
`define OFS_STATUS 4'h0
`define OFS_TXBUF 4'h1
`define OFS_RXBUF 4'h2
`define OFS_IRQ_STAT 4'h3
`define OFS_IRQ_MASK 4'h4
`define OFS_CTRL 4'h5
// status bit positions
`define BIT_TX_FULL 0
`define BIT_RX_FULL 1
`define BIT_RW 2
`define BIT_START 3
`define BIT_STOP 4
`define BIT_DA 5
`define BIT_OV 6
`define BIT_WCOL 7
`define BIT_TEN_BIT 8
// interrupt event bit positions
`define EV_RX 0
`define EV_TXDONE 1
`define EV_OV 2
`define EV_WCOL 3
`define EV_STOP 4
// reset values
`define STATUS_RST 16'h0000
`define MASK_RST 5'h00
`endif

//--- logic/i2c_status_flags.sv
`include "i2c_status_defs.svh"
// Functional notes
// - set ten-bit match on second address byte
// - stop clears ten-bit match flag
// - busy transmit write sets collision flag
// - byte arriving into full buffer: overflow
// - data byte sets, address match clears, slave mode only
// - stop flag follows last bus condition
// - start flag follows last bus condition
// - direction one read, zero write
// - direction taken from each address byte in slave mode
// - receive full set on buffer load
// - receive buffer read clears full flag
// - accepted transmit write sets transmit full
// - shifting finished clears transmit full
module i2c_status_flags
(
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // shift engine side, same clock
    input wire logic start_seen,
    input wire logic stop_seen,
    input wire logic addr_byte_done,
    input wire logic addr_rw_bit,
    input wire logic addr_matched,
    input wire logic ten_bit_second_match,
    input wire logic data_byte_done,
    input wire i2c_status_pkg::byte_t receive_shift_register,
    input wire logic slave_mode,
    input wire logic port_busy,
    input wire logic tx_shift_done,
    output logic tx_load,
    output i2c_status_pkg::byte_t transmit_buffer,
    output logic irq
);
    import i2c_status_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // helpers

    // true when a strobe targets one register index
    // every strobe decode goes through here, so all strobes match alike
    function automatic logic hit(
        input logic strobe, // read or write strobe
        input logic [3:0] addr, // index on the bus
        input logic [3:0] index // index of the target
    );
        return strobe && (addr == index);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////
    // state

    // status flags, one per status bit
    logic ten_bit_addr_matched; // second address byte matched
    logic write_collision_flag; // transmit write refused
    logic receive_overflow_flag; // byte lost to a full buffer
    logic data_addr_reg; // last byte was data
    logic stop_flag_reg; // last condition was stop
    logic start_flag_reg; // last condition was start
    logic rw_reg; // direction of the transfer
    logic receive_full_flag; // receive buffer holds a byte
    logic transmit_full_flag; // transmit buffer holds a byte

    // received byte kept for software
    byte_t receive_buffer; // last accepted byte

    // interrupt state
    logic [4:0] irq_stat_reg; // sticky events
    logic [4:0] irq_mask_reg; // event enables
    logic [4:0] ev_next; // events of this cycle

    // read path
    logic [15:0] status_word; // assembled status

    // decoded register strobes
    logic tx_wr; // transmit buffer write
    logic rx_rd; // receive buffer read
    logic stat_wr; // status word write
    logic stat_rd; // interrupt status read
    logic mask_wr; // interrupt mask write

    // events derived from strobes and flags
    logic wcol_event; // write meets a busy port or a full buffer
    logic ovf_event; // byte meets an unread buffer
    logic tx_clean_wr; // write allowed to load

    ////////////////////////////////////////////////////////////////////
    // strobe decode

    // one strobe per register target
    assign tx_wr = hit(reg_wr, reg_addr, `OFS_TXBUF);
    assign rx_rd = hit(reg_rd, reg_addr, `OFS_RXBUF);
    assign stat_wr = hit(reg_wr, reg_addr, `OFS_STATUS);
    assign stat_rd = hit(reg_rd, reg_addr, `OFS_IRQ_STAT);
    assign mask_wr = hit(reg_wr, reg_addr, `OFS_IRQ_MASK);

    assign wcol_event = tx_wr && (port_busy || transmit_full_flag);
    // byte meets unread buffer
    // a read in the same cycle frees the buffer, so no loss then
    assign ovf_event = data_byte_done && receive_full_flag && !rx_rd;
    assign tx_clean_wr = tx_wr && !wcol_event;

    ////////////////////////////////////////////////////////////////////
    // address and byte flags

    // ten-bit match, set by the engine, cleared by a stop
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            ten_bit_addr_matched <= 1'b0; // power-on clear
        else if (stop_seen)
            ten_bit_addr_matched <= 1'b0;
        else if (ten_bit_second_match)
            ten_bit_addr_matched <= 1'b1;
    end

    // write collision, cleared only by a zero written to its bit
    // a new collision in the clearing cycle wins
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            write_collision_flag <= 1'b0; // power-on clear
        else if (wcol_event)
            write_collision_flag <= 1'b1;
        // software writes a zero
        else if (stat_wr && !reg_wdata[`BIT_WCOL])
            write_collision_flag <= 1'b0;
    end

    // receive overflow, same clearing rule as the collision flag
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            receive_overflow_flag <= 1'b0; // power-on clear
        else if (ovf_event)
            receive_overflow_flag <= 1'b1;
        // software writes a zero
        else if (stat_wr && !reg_wdata[`BIT_OV])
            receive_overflow_flag <= 1'b0;
    end

    // data or address indicator, slave mode only
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            data_addr_reg <= 1'b0; // power-on clear
        else if (slave_mode && addr_byte_done && addr_matched)
            data_addr_reg <= 1'b0;
        else if (slave_mode && data_byte_done)
            data_addr_reg <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // bus conditions

    // last condition seen; a stop beside a start wins
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            stop_flag_reg <= 1'b0;
            start_flag_reg <= 1'b0;
        end
        else if (stop_seen)
        begin
            stop_flag_reg <= 1'b1;
            start_flag_reg <= 1'b0;
        end
        else if (start_seen)
        begin
            stop_flag_reg <= 1'b0;
            start_flag_reg <= 1'b1;
        end
    end

    // direction bit, refreshed by every address byte in slave mode
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            rw_reg <= 1'b0; // power-on: write
        else if (slave_mode && addr_byte_done)
            rw_reg <= addr_rw_bit;
    end

    ////////////////////////////////////////////////////////////////////
    // data buffers

    // receive buffer; a byte that would overwrite an unread one is dropped
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            receive_full_flag <= 1'b0;
            receive_buffer <= 8'h00;
        end
        else if (data_byte_done && (!receive_full_flag || rx_rd))
        begin
            receive_full_flag <= 1'b1;
            receive_buffer <= receive_shift_register;
        end
        else if (rx_rd)
            receive_full_flag <= 1'b0;
        // overflow keeps old byte: no load here
    end

    // transmit buffer; tx_load tells the engine a fresh byte waits
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            transmit_full_flag <= 1'b0;
            transmit_buffer <= 8'h00;
            tx_load <= 1'b0;
        end
        else
        begin
            // load pulse lasts one cycle
            tx_load <= 1'b0;
            // clean write only
            // a collided write never touches the byte in flight
            if (tx_clean_wr)
            begin
                transmit_full_flag <= 1'b1;
                transmit_buffer <= reg_wdata[7:0];
                tx_load <= 1'b1;
            end
            else if (tx_shift_done)
                transmit_full_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupts

    // events of this cycle, one bit per kind
    always_comb
    begin
        ev_next = 5'h00;
        ev_next[`EV_RX] = data_byte_done; // byte arrived
        ev_next[`EV_TXDONE] = tx_shift_done && transmit_full_flag; // byte sent
        ev_next[`EV_OV] = ovf_event; // byte lost
        ev_next[`EV_WCOL] = wcol_event; // write refused
        ev_next[`EV_STOP] = stop_seen; // bus released
    end

    // sticky events; a read clears them but a new event still lands
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            irq_stat_reg <= 5'h00;
        // read clears, set wins
        else if (stat_rd)
            irq_stat_reg <= ev_next;
        // accumulate
        else
            irq_stat_reg <= irq_stat_reg | ev_next;
    end

    // event enables, written whole
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            irq_mask_reg <= `MASK_RST;
        else if (mask_wr)
            irq_mask_reg <= reg_wdata[4:0];
    end

    // level interrupt, one cycle behind the event
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |((irq_stat_reg | ev_next) & irq_mask_reg);
    end

    ////////////////////////////////////////////////////////////////////
    // read path

    // status word; unused bits read as zero
    always_comb
    begin
        status_word = `STATUS_RST;
        // address and error flags
        status_word[`BIT_TEN_BIT] = ten_bit_addr_matched;
        status_word[`BIT_WCOL] = write_collision_flag;
        status_word[`BIT_OV] = receive_overflow_flag;
        // bus conditions and direction
        status_word[`BIT_DA] = data_addr_reg;
        status_word[`BIT_STOP] = stop_flag_reg;
        status_word[`BIT_START] = start_flag_reg;
        status_word[`BIT_RW] = rw_reg;
        // buffer occupancy
        status_word[`BIT_RX_FULL] = receive_full_flag;
        status_word[`BIT_TX_FULL] = transmit_full_flag;
    end

    // read data for one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            reg_rdata <= 16'h0000;
        // strobe cycle: decode the index
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `OFS_STATUS: reg_rdata <= status_word;
                `OFS_TXBUF: reg_rdata <= {8'h00, transmit_buffer};
                `OFS_RXBUF: reg_rdata <= {8'h00, receive_buffer};
                `OFS_IRQ_STAT: reg_rdata <= {11'h000, irq_stat_reg};
                `OFS_IRQ_MASK: reg_rdata <= {11'h000, irq_mask_reg};
                default: reg_rdata <= 16'h0000;
            endcase
        end
        // no strobe: bus reads zero
        else
            reg_rdata <= 16'h0000;
    end
endmodule : i2c_status_flags

//--- logic/i2c_status_pkg.sv
package i2c_status_pkg;
    // one-hot transmit state codes; no module here uses them
    typedef enum logic [2:0] {
        EVT_IDLE = 3'b001,
        EVT_BUSY = 3'b010,
        EVT_DONE = 3'b100
    } tx_state_t;
    typedef logic [7:0] byte_t;
endpackage : i2c_status_pkg

//--- verif/i2c_engine_model.sv
module i2c_engine_model
(
    input wire logic core_clk,
    output logic start_seen,
    output logic stop_seen,
    output logic addr_byte_done,
    output logic addr_rw_bit,
    output logic addr_matched,
    output logic ten_bit_second_match,
    output logic data_byte_done,
    output i2c_status_pkg::byte_t receive_shift_register,
    output logic tx_shift_done
);
    import i2c_status_pkg::*;
    logic [5:0] ev_reg = 6'h00; // one strobe per bus event kind
    logic rw_reg = 1'b0; // direction bit of the address byte
    byte_t byte_reg = 8'h00; // received data byte
    assign start_seen = ev_reg[0];
    assign stop_seen = ev_reg[1];
    assign addr_byte_done = ev_reg[2];
    assign addr_matched = ev_reg[2];
    assign ten_bit_second_match = ev_reg[3];
    assign data_byte_done = ev_reg[4];
    assign tx_shift_done = ev_reg[5];
    assign addr_rw_bit = rw_reg;
    assign receive_shift_register = byte_reg;
    // one event pulse, then lines released with inverted values
    task automatic pulse(input logic [5:0] kind, input logic rw, input byte_t b);
        @(posedge core_clk);
        ev_reg <= kind;
        rw_reg <= rw;
        byte_reg <= b;
        @(posedge core_clk);
        ev_reg <= 6'h00;
        rw_reg <= ~rw;
        byte_reg <= ~b;
    endtask : pulse
endmodule : i2c_engine_model

//--- verif/i2c_status_flags_assertions.sv
module i2c_status_flags_assertions
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic port_busy,
    input wire logic tx_load,
    input wire i2c_status_pkg::byte_t transmit_buffer,
    input wire logic irq
);
    import i2c_status_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_load_has_cause: assert property (tx_load |-> $past(reg_wr) && $past(reg_addr) == 4'h1)
        else $error("tx load without buffer write");
    a_load_data: assert property (tx_load |-> ($past(reg_wdata) & 16'h00ff) == {8'h00, transmit_buffer})
        else $error("tx buffer not the written byte");
    a_busy_refused: assert property (reg_wr && reg_addr == 4'h1 && port_busy |=> !tx_load)
        else $error("busy write accepted");
    a_load_single: assert property (tx_load |=> !tx_load)
        else $error("write into full buffer accepted");
    a_buf_held: assert property (!tx_load && $past(rst_n) |-> $stable(transmit_buffer))
        else $error("tx buffer changed without load");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside answer cycle");
    a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h5 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_irq_masked: assert property ((reg_wr && reg_addr == 4'h4 && reg_wdata[4:0] == 5'h00)
        ##1 !(reg_wr && reg_addr == 4'h4) |=> !irq)
        else $error("irq high with all masked");
endmodule : i2c_status_flags_assertions

//--- verif/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import i2c_status_pkg::*;
    `define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin num_errors++; \
        $display("wrong value %s exp %h got %h", n, e, a); end end
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic slave_mode = 1'b1;
    logic port_busy = 1'b0;
    logic [15:0] reg_rdata, exp_v;
    logic start_seen, stop_seen, addr_byte_done, addr_rw_bit, addr_matched;
    logic ten_bit_second_match, data_byte_done, tx_shift_done, tx_load, irq;
    logic rd_seen = 1'b0;
    byte_t receive_shift_register, transmit_buffer, b1, b2, d;
    logic [15:0] exp_q[$]; // expected read answers, oldest first
    int num_errors = 0;
    int compares = 0;
    int seed = 32'h17a74d14;
    initial forever #25 core_clk = ~core_clk;
    i2c_status_flags dut_u (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .start_seen, .stop_seen, .addr_byte_done, .addr_rw_bit, .addr_matched,
        .ten_bit_second_match, .data_byte_done, .receive_shift_register, .slave_mode,
        .port_busy, .tx_shift_done, .tx_load, .transmit_buffer, .irq);
    i2c_engine_model eng_u (.core_clk, .start_seen, .stop_seen, .addr_byte_done,
        .addr_rw_bit, .addr_matched, .ten_bit_second_match, .data_byte_done,
        .receive_shift_register, .tx_shift_done);
    // compare each read answer with the oldest note
    always @(negedge core_clk)
    begin
        if (rd_seen)
        begin
            exp_v = exp_q.pop_front();
            `CHK("reg_rdata", exp_v, reg_rdata)
        end
        rd_seen = reg_rd;
    end
    // one register cycle; for a read v is the expected answer
    task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] v);
        if (!w)
            exp_q.push_back(v);
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask : acc
    task automatic stop_test;
        if (num_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (3000) @(posedge core_clk);
        num_errors++;
        stop_test();
    end
    initial
    begin
        b1 = 8'($random(seed));
        b2 = ~b1; // differs from b1, so a lost byte shows
        d = 8'($random(seed));
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        acc(0, 4'h0, 16'h0000);
        eng_u.pulse(6'h01, 1'b0, 8'h00);
        acc(0, 4'h0, 16'h0008);
        eng_u.pulse(6'h04, 1'b1, 8'h00);
        acc(0, 4'h0, 16'h000c);
        eng_u.pulse(6'h08, 1'b0, 8'h00);
        acc(0, 4'h0, 16'h010c);
        eng_u.pulse(6'h10, 1'b0, b1);
        acc(0, 4'h0, 16'h012e);
        eng_u.pulse(6'h10, 1'b0, b2);
        acc(0, 4'h0, 16'h016e);
        acc(0, 4'h2, {8'h00, b1});
        acc(0, 4'h0, 16'h016c);
        acc(1, 4'h0, 16'h0000);
        acc(0, 4'h0, 16'h012c);
        acc(1, 4'h1, {8'h00, d});
        acc(1, 4'h1, {8'h00, ~d});
        acc(0, 4'h0, 16'h01ad);
        eng_u.pulse(6'h20, 1'b0, 8'h00);
        acc(0, 4'h0, 16'h01ac);
        acc(1, 4'h0, 16'h0000);
        port_busy <= 1'b1;
        acc(1, 4'h1, {8'h00, ~d});
        port_busy <= 1'b0;
        acc(0, 4'h0, 16'h01ac);
        `CHK("transmit_buffer", d, transmit_buffer)
        acc(1, 4'h0, 16'h0000);
        eng_u.pulse(6'h02, 1'b0, 8'h00);
        acc(0, 4'h0, 16'h0034);
        eng_u.pulse(6'h04, 1'b0, 8'h00);
        acc(0, 4'h0, 16'h0010);
        slave_mode <= 1'b0;
        eng_u.pulse(6'h04, 1'b1, 8'h00);
        acc(0, 4'h0, 16'h0010);
        slave_mode <= 1'b1;
        acc(0, 4'h9, 16'h0000);
        `CHK("irq", 1'b0, irq)
        acc(1, 4'h4, 16'h001f);
        repeat (2) @(posedge core_clk);
        #1 `CHK("irq", 1'b1, irq)
        acc(0, 4'h3, 16'h001f);
        acc(0, 4'h3, 16'h0000);
        repeat (2) @(posedge core_clk);
        #1 `CHK("irq", 1'b0, irq)
        acc(1, 4'h4, 16'h0000);
        repeat (3) @(posedge core_clk);
        stop_test();
    end
endmodule : tb_top
bind i2c_status_flags i2c_status_flags_assertions chk_u (.core_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_busy, .tx_load, .transmit_buffer, .irq);
